// ### ccp_compare_pwm.sv
`timescale 1ns/1ps
// What this block does
// - compare full 16-bit value against timer1 count
// - match sets, clears or keeps output pin
// - modes 1000 set,1001 clear,1010 flag,1011 trigger
// - mode 0000 resets unit; 11xx selects pwm
// - flag rises with the pin action
// - control write of zero clears compare latch
// - software-interrupt mode leaves pin untouched
// - special event resets timer1, starts conversion
// - special event never sets timer1 overflow flag
// - pwm waveform with ten-bit duty
// - period is (period+1)*4*prescale clocks
// - period end clears timer2, sets pin unless new duty is zero, loads duty
// - duty is low byte plus control bits 5:4
// - duty writes apply at period end only
// - high byte read-only while pwm runs
// - pin clears when duty equals extended timer2
// - high time is duty*clock*prescale
// - duty beyond period gives full high
// - control write of zero clears pwm latch
module ccp_compare_pwm
    import ccp_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic [15:0] timer1_count_pair,
    output logic        unit_output_pin,
    output logic        unit_output_pin_oe_n,
    output logic        unit_interrupt_flag,
    output logic        unit_interrupt_enable,
    output logic        timer1_reset,
    output logic        adc_start
);

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        setup;
    logic        wr_en;
    logic [9:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    logic [5:0]  ctl_q;
    logic [7:0]  duty_lo_q;
    logic [7:0]  duty_hi_q;
    logic [1:0]  dlow2_q;
    logic [7:0]  timer2_count_q;
    logic [6:0]  t2ctl_q;
    logic [7:0]  period_q;
    logic [7:0]  dir_q;
    logic        flag_q;
    logic        ien_q;
    logic        pin_q;
    logic [5:0]  fine_q;
    logic        hit_q;
    logic [15:0] t1_prev_q;
    logic        t1_rst_q;
    logic        adc_q;

    assign setup = psel & ~penable;
    // no wait states: ready rises in the first access cycle
    assign wr_en = psel & penable & pready_q & pwrite;
    assign idx   = paddr[11:2];
    assign wbyte = pwdata[7:0];

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            IDX_FLAGS:   rd_byte = {5'h00, flag_q, 2'b00};
            IDX_T1_LO:   rd_byte = timer1_count_pair[7:0];
            IDX_T1_HI:   rd_byte = timer1_count_pair[15:8];
            IDX_T2_CNT:  rd_byte = timer2_count_q;
            IDX_T2_CTL:  rd_byte = {1'b0, t2ctl_q};
            IDX_DUTY_LO: rd_byte = duty_lo_q;
            IDX_DUTY_HI: rd_byte = duty_hi_q;
            IDX_CTL:     rd_byte = {2'b00, ctl_q};
            IDX_DIR:     rd_byte = dir_q;
            IDX_ENABLES: rd_byte = {5'h00, ien_q, 2'b00};
            IDX_PERIOD:  rd_byte = period_q;
            default:     rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            prdata_q  <= (setup && !pwrite) ? {24'h000000, rd_byte}
                                            : 32'h0000_0000;
            pslverr_q <= setup & ~rd_hit;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    unit_mode_t  mode;
    logic        ctl_wr;
    logic        ctl_zero;
    logic        match;
    logic        cmp_act;
    logic [5:0]  fine_lim;
    logic        tick;
    logic        period_end;
    logic        pwm_period;
    logic [1:0]  low2;
    logic        pwm_clear;
    logic [9:0]  duty_next;
    logic        t2_wr;
    logic        step;

    assign mode     = mode_of(ctl_q[3:0]);
    assign ctl_wr   = wr_en && idx == IDX_CTL;
    assign ctl_zero = ctl_wr && wbyte[5:0] == 6'h00;
    assign t2_wr    = wr_en && (idx == IDX_T2_CNT || idx == IDX_T2_CTL);

    assign match = timer1_count_pair == {duty_hi_q, duty_lo_q};
    // a match held on the same count acts only once
    assign cmp_act = mode == unit_compare && match
        && !(hit_q && timer1_count_pair == t1_prev_q);

    always_comb begin
        unique case (t2ctl_q[1:0])
            2'b00:   fine_lim = FINE_LIM_1;
            2'b01:   fine_lim = FINE_LIM_4;
            default: fine_lim = FINE_LIM_16;
        endcase
    end

    // low bits follow quarter phase or prescaler bits;
    // step marks the last clock before they advance
    always_comb begin
        step = t2ctl_q[T2_ON_BIT];
        unique case (t2ctl_q[1:0])
            2'b00: begin
                low2 = fine_q[1:0];
            end
            2'b01: begin
                low2 = fine_q[3:2];
                step = step && fine_q[1:0] == 2'b11;
            end
            default: begin
                low2 = fine_q[5:4];
                step = step && fine_q[3:0] == 4'hf;
            end
        endcase
    end

    assign tick       = t2ctl_q[T2_ON_BIT] && fine_q == fine_lim;
    assign period_end = tick && timer2_count_q == period_q;
    assign pwm_period = period_end && mode == unit_pwm;
    assign duty_next  = {duty_lo_q, ctl_q[5:4]};
    // duty beyond the period never matches, so pin stays high;
    // clear on the edge into the matching count so the high
    // time is exactly duty clocks times prescale
    assign pwm_clear  = mode == unit_pwm && step
        && {duty_hi_q, dlow2_q} == {timer2_count_q, low2} + 10'h001;

    // ------------------------------------------------------------
    // control and duty registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_q <= 6'h00;
        else if (ctl_wr)
            ctl_q <= wbyte[5:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            duty_lo_q <= 8'h00;
        else if (wr_en && idx == IDX_DUTY_LO)
            duty_lo_q <= wbyte;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_hi_q <= 8'h00;
            dlow2_q   <= 2'b00;
        end else if (pwm_period) begin
            duty_hi_q <= duty_next[9:2];
            dlow2_q   <= duty_next[1:0];
        end else if (wr_en && idx == IDX_DUTY_HI && mode != unit_pwm) begin
            duty_hi_q <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q    <= DIR_RESET;
            ien_q    <= 1'b0;
            period_q <= PERIOD_RESET;
            t2ctl_q  <= 7'h00;
        end else if (wr_en) begin
            if (idx == IDX_DIR)
                dir_q <= wbyte;
            if (idx == IDX_ENABLES)
                ien_q <= wbyte[FLAG_BIT];
            if (idx == IDX_PERIOD)
                period_q <= wbyte;
            if (idx == IDX_T2_CTL)
                t2ctl_q <= wbyte[6:0];
        end
    end

    // ------------------------------------------------------------
    // timer2 time base
    // ------------------------------------------------------------
    // writes to count or control restart the prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fine_q <= 6'h00;
        else if (t2_wr || tick)
            fine_q <= 6'h00;
        else if (t2ctl_q[T2_ON_BIT])
            fine_q <= fine_q + 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timer2_count_q <= 8'h00;
        else if (wr_en && idx == IDX_T2_CNT)
            timer2_count_q <= wbyte;
        else if (period_end)
            timer2_count_q <= 8'h00;
        else if (tick)
            timer2_count_q <= timer2_count_q + 8'h01;
    end

    // ------------------------------------------------------------
    // output latch shared by compare and pwm
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_q <= 1'b0;
        else if (ctl_zero || mode == unit_off)
            pin_q <= 1'b0;
        else if (pwm_period)
            pin_q <= duty_next != 10'h000;
        else if (pwm_clear)
            pin_q <= 1'b0;
        else if (cmp_act && ctl_q[3:0] == MODE_CMP_SET)
            pin_q <= 1'b1;
        else if (cmp_act && ctl_q[3:0] == MODE_CMP_CLR)
            pin_q <= 1'b0;
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_q <= 1'b0;
        else if (cmp_act)
            flag_q <= 1'b1;
        else if (wr_en && idx == IDX_FLAGS)
            flag_q <= wbyte[FLAG_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q     <= 1'b0;
            t1_prev_q <= 16'h0000;
        end else begin
            hit_q     <= match && mode == unit_compare;
            t1_prev_q <= timer1_count_pair;
        end
    end

    // trigger pulse only; overflow flag lives with timer1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_rst_q <= 1'b0;
            adc_q    <= 1'b0;
        end else begin
            t1_rst_q <= cmp_act && ctl_q[3:0] == MODE_CMP_SEV;
            adc_q    <= cmp_act && ctl_q[3:0] == MODE_CMP_SEV;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign unit_output_pin       = pin_q;
    assign unit_output_pin_oe_n  = dir_q[PIN_BIT];
    assign unit_interrupt_flag   = flag_q;
    assign unit_interrupt_enable = ien_q;
    assign timer1_reset          = t1_rst_q;
    assign adc_start             = adc_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_zero_ctl_low: assert property (
        ctl_zero |=> !unit_output_pin)
        else $error("control zero did not clear pin");

    a_cmp_set_pin: assert property (
        cmp_act && ctl_q[3:0] == MODE_CMP_SET && !ctl_zero
        |=> unit_output_pin && unit_interrupt_flag)
        else $error("set-on-match missed pin or flag");

    a_cmp_clr_pin: assert property (
        cmp_act && ctl_q[3:0] == MODE_CMP_CLR
        |=> !unit_output_pin && unit_interrupt_flag)
        else $error("clear-on-match missed pin or flag");

    a_swi_pin_hold: assert property (
        cmp_act && ctl_q[3:0] == MODE_CMP_SWI && !ctl_wr
        |=> unit_output_pin == $past(unit_output_pin)
            && unit_interrupt_flag)
        else $error("software mode touched the pin");

    a_event_trigger: assert property (
        cmp_act && ctl_q[3:0] == MODE_CMP_SEV
        |=> timer1_reset && adc_start ##1 !timer1_reset)
        else $error("special event pulse wrong");

    a_once_per_value: assert property (
        cmp_act ##1 timer1_count_pair == $past(timer1_count_pair)
        |-> !cmp_act)
        else $error("second action on same count");

    a_period_latch: assert property (
        pwm_period |=> timer2_count_q == 8'h00
            && {duty_hi_q, dlow2_q} == $past(duty_next))
        else $error("period end did not reload");

    a_high_readonly: assert property (
        wr_en && idx == IDX_DUTY_HI && mode == unit_pwm && !pwm_period
        |=> $stable(duty_hi_q))
        else $error("high byte written in pwm mode");

    a_pwm_clear_low: assert property (
        pwm_clear && !pwm_period |=> !unit_output_pin)
        else $error("duty match did not clear pin");

    a_apb_answer: assert property (
        setup |=> pready ##1 !pready)
        else $error("apb ready timing wrong");

    c_cmp_set: cover property (
        cmp_act && ctl_q[3:0] == MODE_CMP_SET);
    c_event: cover property (
        cmp_act && ctl_q[3:0] == MODE_CMP_SEV);
    c_pwm_cycle: cover property (
        pwm_period && duty_next != 10'h000 ##[1:1000] pwm_clear);
    c_full_high: cover property (
        pwm_period ##1 unit_output_pin [*8]);

endmodule // ccp_compare_pwm

// ### ccp_pkg.sv
package ccp_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_FLAGS   = 10'h00c;
    localparam logic [9:0] IDX_T1_LO   = 10'h00e;
    localparam logic [9:0] IDX_T1_HI   = 10'h00f;
    localparam logic [9:0] IDX_T2_CNT  = 10'h011;
    localparam logic [9:0] IDX_T2_CTL  = 10'h012;
    localparam logic [9:0] IDX_DUTY_LO = 10'h015;
    localparam logic [9:0] IDX_DUTY_HI = 10'h016;
    localparam logic [9:0] IDX_CTL     = 10'h017;
    localparam logic [9:0] IDX_DIR     = 10'h087;
    localparam logic [9:0] IDX_ENABLES = 10'h08c;
    localparam logic [9:0] IDX_PERIOD  = 10'h092;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RESET    = 8'h3f;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam int         FLAG_BIT     = 2;
    localparam int         PIN_BIT      = 2;
    localparam int         T2_ON_BIT    = 2;

    // ------------------------------------------------------------
    // mode field encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWI = 4'ha;
    localparam logic [3:0] MODE_CMP_SEV = 4'hb;

    // ------------------------------------------------------------
    // timer2 sub-count limits: four quarter cycles times prescale
    // ------------------------------------------------------------
    localparam logic [5:0] FINE_LIM_1  = 6'h03;
    localparam logic [5:0] FINE_LIM_4  = 6'h0f;
    localparam logic [5:0] FINE_LIM_16 = 6'h3f;

    typedef enum {unit_off, unit_capture, unit_compare, unit_pwm}
        unit_mode_t;

    function automatic unit_mode_t mode_of(input logic [3:0] m);
        if (m == MODE_OFF)
            return unit_off;
        else if (m[3:2] == 2'b11)
            return unit_pwm;
        else if (m[3:2] == 2'b10)
            return unit_compare;
        else
            return unit_capture;
    endfunction

endpackage

// ### pin_load.sv
`timescale 1ns/1ps
module pin_load (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic unit_output_pin,
    input  wire logic unit_output_pin_oe_n,
    output int        n_rise,
    output int        n_high
);
    logic last_q;
    logic level;

    // undriven pin floats: show the inverse of the last level
    assign level = unit_output_pin_oe_n ? ~last_q : unit_output_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 1'b0;
            n_rise <= 0;
            n_high <= 0;
        end else begin
            last_q <= level;
            if (level && !last_q)
                n_rise <= n_rise + 1;
            if (level)
                n_high <= n_high + 1;
        end
    end
endmodule // pin_load

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import ccp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [15:0] t1      = 16'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        oe_n;
    logic        flag;
    logic        ien;
    logic        t1_rst;
    logic        adc;
    logic [31:0] rd;
    logic        err;
    logic        exp_pin = 1'b0;
    int          n_rise;
    int          n_high;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          seed       = 88025;
    logic [9:0]  ri [9] = '{IDX_FLAGS, IDX_T2_CNT, IDX_T2_CTL, IDX_DUTY_LO,
        IDX_DUTY_HI, IDX_CTL, IDX_DIR, IDX_ENABLES, IDX_PERIOD};
    logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h3f, 8'h00, 8'hff};
    logic [3:0]  ml [5] = '{MODE_CMP_SET, MODE_CMP_SWI, MODE_CMP_SEV,
        MODE_CMP_CLR, MODE_CMP_SET};

    ccp_compare_pwm DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer1_count_pair(t1),
        .unit_output_pin(pin), .unit_output_pin_oe_n(oe_n),
        .unit_interrupt_flag(flag), .unit_interrupt_enable(ien),
        .timer1_reset(t1_rst), .adc_start(adc));

    pin_load load (
        .pclk(pclk), .presetn(presetn), .unit_output_pin(pin),
        .unit_output_pin_oe_n(oe_n), .n_rise(n_rise), .n_high(n_high));

    always #2.5 pclk = ~pclk;

    function automatic int rnd(input int n);
        rnd = ($random(seed) & 32'h7fffffff) % n;
    endfunction

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] i,
                       input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16)
            n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk({err, rd}, {1'b0, 24'h0, e});
    endtask

    task automatic cmp_case(input logic [3:0] m);
        logic [15:0] v;
        v = 16'($random(seed));
        t1 <= v ^ 16'h8000;
        apb(1'b1, IDX_DUTY_LO, v[7:0]);
        apb(1'b1, IDX_DUTY_HI, v[15:8]);
        apb(1'b1, IDX_FLAGS, 8'h00);
        apb(1'b1, IDX_CTL, {4'h0, m});
        cyc(3);
        chk(flag, 1'b0);
        t1 <= v;
        cyc(2);
        if (m == MODE_CMP_SET)
            exp_pin = 1'b1;
        else if (m == MODE_CMP_CLR)
            exp_pin = 1'b0;
        chk({pin, flag, t1_rst, adc}, {exp_pin, 1'b1, {2{m == MODE_CMP_SEV}}});
        rchk(IDX_FLAGS, 8'h04);
        apb(1'b1, IDX_FLAGS, 8'h00);
        cyc(2);
        chk({flag, t1_rst, pin}, {2'b00, exp_pin});
        t1 <= v + 16'h1;
        cyc(1);
    endtask

    task automatic pwm_case(input logic [7:0] pr, input logic [1:0] pc,
                            input logic [9:0] d);
        int f, p, h, r0, h0;
        f = (pc == 2'd0) ? 1 : (pc == 2'd1) ? 4 : 16;
        p = (pr + 1) * 4 * f;
        h = (d * f < p) ? d * f : p;
        apb(1'b1, IDX_PERIOD, pr);
        apb(1'b1, IDX_DUTY_LO, d[9:2]);
        apb(1'b1, IDX_CTL, {2'b00, d[1:0], 2'b11, 2'(rnd(4))});
        apb(1'b1, IDX_T2_CTL, {5'h00, 1'b1, pc});
        apb(1'b1, IDX_T2_CNT, 8'h00);
        cyc(3 * p + 4);
        r0 = n_rise;
        h0 = n_high;
        cyc(2 * p);
        chk(n_high - h0, 2 * h);
        chk(n_rise - r0, (h > 0 && h < p) ? 2 : 0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk(oe_n, 1'b1);
        for (int i = 0; i < 9; i++)
            rchk(ri[i], rv[i]);
        apb(1'b0, 10'h3ff, 8'h00);
        chk({err, rd}, {1'b1, 32'h0});
        t1 <= 16'($random(seed));
        cyc(1);
        rchk(IDX_T1_HI, t1[15:8]);
        apb(1'b1, IDX_DIR, 8'h3b);
        apb(1'b1, IDX_ENABLES, 8'h04);
        cyc(1);
        chk({oe_n, ien}, 2'b01);
        for (int i = 0; i < 5; i++)
            cmp_case(ml[i]);
        apb(1'b1, IDX_CTL, 8'h00);
        cyc(1);
        chk(pin, 1'b0);
        apb(1'b1, IDX_PERIOD, 8'hff);
        apb(1'b1, IDX_DUTY_LO, 8'h11);
        apb(1'b1, IDX_T2_CTL, 8'h04);
        apb(1'b1, IDX_CTL, 8'h0c);
        cyc(1100);
        rchk(IDX_DUTY_HI, 8'h11);
        apb(1'b1, IDX_T2_CNT, 8'h00);
        apb(1'b1, IDX_DUTY_LO, 8'h22);
        apb(1'b1, IDX_DUTY_HI, 8'h5a);
        rchk(IDX_DUTY_HI, 8'h11);
        cyc(1100);
        rchk(IDX_DUTY_HI, 8'h22);
        pwm_case(8'h00, 2'd0, 10'd2);
        pwm_case(8'h03, 2'd0, 10'(1 + rnd(15)));
        pwm_case(8'h03, 2'd0, 10'd0);
        pwm_case(8'h03, 2'd0, 10'd16);
        pwm_case(8'h01, 2'd1, 10'(1 + rnd(7)));
        pwm_case(8'h00, 2'(2 + rnd(2)), 10'(1 + rnd(3)));
        pwm_case(8'h01, 2'd0, 10'h3ff);
        apb(1'b1, IDX_CTL, 8'h00);
        cyc(1);
        chk(pin, 1'b0);
        final_report();
    end

    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
endmodule // testbench
